/* src/pmwc_pkg.sv */
// Notes on behaviour
// RQ1: Indirect word 4 read gives RTC wake flag bit 8, pin flags 5:0.
// RQ2: Reading a wakeup status word clears its flags.
// RQ3: Indirect word 5 read gives a second status word, same layout and clearing.
// RQ4: Word 4 write sets edge and filter fields of pins 3 down to 0.
// RQ5: Word 5 write sets edge and filter of pins 5 and 4; bits 15:8 ignored.
// RQ6: Software never accesses reserved indirect addresses 6 and 7.
// RQ7: Control bit 3 selects read of status or write of configuration.
// RQ8: Filter code needs 0, 2, 8 or 64 stable slow clock pulses.
// RQ9: Edge code selects none, rising, falling or both edges.
// RQ10: Processor active after reset; standby on sleep-control write of 0x01.
// RQ11: Standby processor wakes on USB, radio, pin or RTC interrupt.
// RQ12: Radio powered down after reset; software alone changes its state.
// RQ13: USB active after reset; suspends on USB sleep write of 0x01.
// RQ14: Suspended USB resumes by software or by host resume.
// RQ15: PLL on after reset; software enable bit 7 rules while USB suspended and processor active.
// RQ16: Program-select pin high means flash programming; power states do not apply.
// RQ17: PLL on if USB active, off if suspended with standby, else software.
// RQ18: Enabled PLL multiplies the 16 MHz oscillator by three to 48 MHz.
// RQ19: Slow 32 kHz clock derived from oscillator, runs in every state.
// RQ20: Sleep-control write stops the processor clock.
// RQ21: Processor clock programmable from 64 kHz to 16 MHz.
// RQ22: Wakeup configuration governs each event that resumes the processor.
// RQ23: Wake field: 00 if enabled, 10 always, 11 ignore, 01 reserved.
// RQ24: Any nonzero value in sleep-control bits 2:0 enters standby.
// RQ25: Control bit 4 reads 1 while last control write is pending.
// RQ26: Selected debounced pin edge sets its flag and the common wakeup event.
// RQ27: Software polls the busy bit to zero before another indirect access.
package pmwc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CLK_CTRL   = 8'ha3;
  localparam logic [7:0] A_PWR_DOWN   = 8'ha4;
  localparam logic [7:0] A_WAKE_CONF  = 8'ha5;
  localparam logic [7:0] A_IND_HIGH   = 8'hab;
  localparam logic [7:0] A_IND_LOW    = 8'hac;
  localparam logic [7:0] A_IND_CTRL   = 8'had;
  localparam logic [7:0] A_USB_SLEEP  = 8'hb8;
  localparam logic [7:0] A_RADIO_CTRL = 8'hb9;

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam logic [2:0] IA_WAKE_A    = 3'h4;
  localparam logic [2:0] IA_WAKE_B    = 3'h5;
  localparam int         IC_BUSY      = 4;
  localparam int         IC_WRITE     = 3;
  localparam int         PLL_EN_BIT   = 7;
  localparam int         PD_LF_BIT    = 3;
  localparam int         STAT_RTC_BIT = 8;
  localparam logic [7:0] CLK_CTRL_RST = 8'h80;
  localparam logic [7:0] SLEEP_CMD    = 8'h01;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] WC_IF_EN     = 2'h0;
  localparam logic [1:0] WC_ALWAYS    = 2'h2;
  localparam int         IEN_RF       = 1;
  localparam int         IEN_USBWU    = 3;
  localparam int         IEN_USB      = 4;
  localparam int         IEN_WU       = 5;
  localparam logic [1:0] RADIO_PDOWN  = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_HZ   = 100_000_000;
  localparam int         LF_CLK_HZ    = 32_000;
  localparam int         LF_CYC       = SYS_CLK_HZ / LF_CLK_HZ;
  localparam logic [11:0] LF_LAST     = 12'(LF_CYC - 1);
  localparam logic [11:0] LF_HALF     = 12'(LF_CYC / 2);

  function automatic logic [6:0] db_len(input logic [1:0] code);
    unique case (code)
      2'h0: db_len = 7'h00;
      2'h1: db_len = 7'h02;
      2'h2: db_len = 7'h08;
      2'h3: db_len = 7'h40;
    endcase
  endfunction

  function automatic logic wake_ok(input logic [1:0] f, input logic en, input logic ev);
    wake_ok = ev & ((f == WC_ALWAYS) | ((f == WC_IF_EN) & en));
  endfunction

endpackage

/* src/pmwc_ctrl.sv */
module pmwc_ctrl
  import pmwc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_interrupt_enable_group_one,
  input  wire logic       i_rf_irq,
  input  wire logic       i_usb_irq,
  input  wire logic       i_rtc_wakeup,
  input  wire logic       i_usb_resume,
  input  wire logic [5:0] i_port0_pin,
  input  wire logic       i_program_select_pin,
  output logic [7:0]      o_sfr_rdata,
  output logic            o_cpu_standby,
  output logic            o_usb_suspend,
  output logic            o_pll_on,
  output logic [3:0]      o_cpu_clk_code,
  output logic [1:0]      o_radio_mode,
  output logic            o_flash_program_select_pin_mode,
  output logic            o_low_frequency_clock,
  output logic            o_common_wakeup_event
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [5:0]  pin_m_q;
  logic [5:0]  pin_s_q;
  logic [1:0]  misc_m_q;
  logic [1:0]  misc_s_q;
  logic [11:0] lf_cnt_q;
  logic        lf_tick_q;
  logic        lf_clk_q;
  logic [3:0]  pin_cfg_q [6];
  logic [6:0]  db_cnt_q [6];
  logic [5:0]  filt_q;
  logic [5:0]  pin_evt_q;
  logic        rtc_evt_q;
  logic [6:0]  set_w;
  logic [6:0]  stat_a_q;
  logic [6:0]  stat_b_q;
  logic        busy_q;
  logic        op_wr_q;
  logic [2:0]  op_addr_q;
  logic        op_done;
  logic        rd_a;
  logic        rd_b;
  logic [15:0] data_q;
  logic [7:0]  clk_ctrl_q;
  logic [7:0]  wake_conf_q;
  logic [1:0]  radio_q;
  logic        standby_q;
  logic        suspend_q;
  logic        pll_q;
  logic        wu_q;
  logic        wake;
  logic        program_select_pin;
  logic [7:0]  rdata_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Both status words share one layout: flag 6 is the RTC, flags 5:0 the pins.
  function automatic logic [15:0] stat_word(input logic [6:0] s);
    stat_word               = 16'h0000;
    stat_word[STAT_RTC_BIT] = s[6];
    stat_word[5:0]          = s[5:0];
  endfunction

  assign program_select_pin    = misc_s_q[0];
  assign op_done = busy_q & lf_tick_q;
  assign rd_a    = op_done & ~op_wr_q & (op_addr_q == IA_WAKE_A);
  assign rd_b    = op_done & ~op_wr_q & (op_addr_q == IA_WAKE_B);
  assign set_w   = {rtc_evt_q, pin_evt_q};

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_m_q  <= 6'h00;
      pin_s_q  <= 6'h00;
      misc_m_q <= 2'h0;
      misc_s_q <= 2'h0;
    end else begin
      pin_m_q  <= i_port0_pin;
      pin_s_q  <= pin_m_q;
      misc_m_q <= {i_usb_resume, i_program_select_pin};
      misc_s_q <= misc_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Slow clock
  // ----------------------------------------------------------------
  // The slow clock is a tick strobe plus a square wave, kept free running
  // in every power state so that pin filtering never stops.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      lf_cnt_q  <= 12'h000;
      lf_tick_q <= 1'b0;
      lf_clk_q  <= 1'b0;
    end else begin
      lf_tick_q <= (lf_cnt_q == LF_LAST); // RQ19
      if (lf_cnt_q == LF_LAST) begin
        lf_cnt_q <= 12'h000;
      end else begin
        lf_cnt_q <= lf_cnt_q + 12'h001;
      end
      lf_clk_q <= (lf_cnt_q < LF_HALF);
    end
  end

  // ----------------------------------------------------------------
  // Pin filters and edge detection
  // ----------------------------------------------------------------
  // The edge is judged on the filtered level, so a glitch shorter than the
  // selected number of slow ticks can never raise a flag.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      filt_q    <= 6'h00;
      pin_evt_q <= 6'h00;
      for (int p = 0; p < 6; p++) begin
        db_cnt_q[p] <= 7'h00;
      end
    end else begin
      pin_evt_q <= 6'h00;
      for (int p = 0; p < 6; p++) begin
        if (lf_tick_q) begin
          if (pin_s_q[p] == filt_q[p]) begin
            db_cnt_q[p] <= 7'h00;
          end else if (db_cnt_q[p] + 7'h01 >= db_len(pin_cfg_q[p][1:0])) begin // RQ8
            db_cnt_q[p] <= 7'h00;
            filt_q[p]   <= pin_s_q[p];
            pin_evt_q[p] <= pin_s_q[p] ? pin_cfg_q[p][2] : pin_cfg_q[p][3]; // RQ9 RQ26
          end else begin
            db_cnt_q[p] <= db_cnt_q[p] + 7'h01;
          end
        end
      end
    end
  end

  // The RTC pulse is registered so that it sets its flags in step with the pins.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rtc_evt_q <= 1'b0;
    end else begin
      rtc_evt_q <= i_rtc_wakeup;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wu_q <= 1'b0;
    end else begin
      wu_q <= |set_w; // RQ26
    end
  end

  // ----------------------------------------------------------------
  // Wakeup status words
  // ----------------------------------------------------------------
  // A new event in the cycle of a read survives into the next read.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      stat_a_q <= 7'h00;
      stat_b_q <= 7'h00;
    end else begin
      stat_a_q <= (rd_a ? 7'h00 : stat_a_q) | set_w; // RQ2
      stat_b_q <= (rd_b ? 7'h00 : stat_b_q) | set_w; // RQ3
    end
  end

  // ----------------------------------------------------------------
  // Indirect access engine
  // ----------------------------------------------------------------
  // An access is carried out on the next slow clock tick, which is why
  // software must wait on the busy bit; a control write while busy is dropped.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_q    <= 1'b0;
      op_wr_q   <= 1'b0;
      op_addr_q <= 3'h0;
    end else if (i_sfr_wr && i_sfr_addr == A_IND_CTRL && !busy_q) begin
      busy_q    <= 1'b1; // RQ25
      op_wr_q   <= i_sfr_wdata[IC_WRITE]; // RQ7
      op_addr_q <= i_sfr_wdata[2:0];
    end else if (op_done) begin
      busy_q    <= 1'b0; // RQ25
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      data_q <= 16'h0000;
    end else if (rd_a) begin
      data_q <= stat_word(stat_a_q); // RQ1
    end else if (rd_b) begin
      data_q <= stat_word(stat_b_q); // RQ3
    end else if (i_sfr_wr && i_sfr_addr == A_IND_HIGH) begin
      data_q[15:8] <= i_sfr_wdata;
    end else if (i_sfr_wr && i_sfr_addr == A_IND_LOW) begin
      data_q[7:0] <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < 6; p++) begin
        pin_cfg_q[p] <= 4'h0;
      end
    end else if (op_done && op_wr_q) begin
      if (op_addr_q == IA_WAKE_A) begin
        for (int p = 0; p < 4; p++) begin
          pin_cfg_q[p] <= data_q[4*p +: 4]; // RQ4
        end
      end else if (op_addr_q == IA_WAKE_B) begin
        pin_cfg_q[4] <= data_q[3:0]; // RQ5
        pin_cfg_q[5] <= data_q[7:4]; // RQ5
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      clk_ctrl_q  <= CLK_CTRL_RST;
      wake_conf_q <= 8'h00;
      radio_q     <= RADIO_PDOWN; // RQ12
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == A_CLK_CTRL) begin
        clk_ctrl_q <= i_sfr_wdata & 8'hf3; // RQ21
      end
      if (i_sfr_addr == A_WAKE_CONF) begin
        wake_conf_q <= i_sfr_wdata; // RQ22
      end
      if (i_sfr_addr == A_RADIO_CTRL) begin
        radio_q <= i_sfr_wdata[1:0]; // RQ12
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor, USB and PLL states
  // ----------------------------------------------------------------
  // A reserved field code wakes on nothing, so a stray value only ignores a source.
  // The host resume is taken from its synchroniser, never from the raw pin.
  assign wake = wake_ok(wake_conf_q[7:6], i_interrupt_enable_group_one[IEN_RF], i_rf_irq) // RQ11 RQ22 RQ23
              | wake_ok(wake_conf_q[5:4], i_interrupt_enable_group_one[IEN_WU], wu_q)
              | wake_ok(wake_conf_q[3:2], i_interrupt_enable_group_one[IEN_USB], i_usb_irq)
              | wake_ok(wake_conf_q[1:0], i_interrupt_enable_group_one[IEN_USBWU], misc_s_q[1]);

  // Programming mode holds the processor, USB and PLL awake so the flash loader is never
  // left without a clock.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      standby_q <= 1'b0; // RQ10
    end else if (program_select_pin) begin
      standby_q <= 1'b0; // RQ16
    end else if (i_sfr_wr && i_sfr_addr == A_PWR_DOWN && i_sfr_wdata[2:0] != 3'h0) begin
      standby_q <= 1'b1; // RQ10 RQ20 RQ24
    end else if (wake) begin
      standby_q <= 1'b0; // RQ11
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      suspend_q <= 1'b0; // RQ13
    end else if (program_select_pin || misc_s_q[1]) begin
      suspend_q <= 1'b0; // RQ14 RQ16
    end else if (i_sfr_wr && i_sfr_addr == A_USB_SLEEP) begin
      suspend_q <= (i_sfr_wdata == SLEEP_CMD); // RQ13 RQ14
    end
  end

  // The PLL output itself is analogue: this flag enables the x3 multiplier.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pll_q <= 1'b1; // RQ15
    end else if (!suspend_q || program_select_pin) begin
      pll_q <= 1'b1; // RQ17 RQ18
    end else if (standby_q) begin
      pll_q <= 1'b0; // RQ17
    end else begin
      pll_q <= clk_ctrl_q[PLL_EN_BIT]; // RQ15 RQ17
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Read data is registered and held until the next read strobe, so a slow
  // poller may take it at any later cycle.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        A_CLK_CTRL:   rdata_q <= clk_ctrl_q;
        A_PWR_DOWN:   rdata_q <= {4'h0, lf_clk_q, 3'h0};
        A_WAKE_CONF:  rdata_q <= wake_conf_q;
        A_IND_HIGH:   rdata_q <= data_q[15:8];
        A_IND_LOW:    rdata_q <= data_q[7:0];
        A_IND_CTRL:   rdata_q <= {3'h0, busy_q, op_wr_q, op_addr_q}; // RQ25
        A_USB_SLEEP:  rdata_q <= {7'h00, suspend_q};
        A_RADIO_CTRL: rdata_q <= {6'h00, radio_q};
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cpu_clk_code <= 4'h8;
    end else begin
      o_cpu_clk_code <= pll_q ? {1'b1, clk_ctrl_q[6:4]} : {2'h0, clk_ctrl_q[1:0]}; // RQ21
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_flash_program_select_pin_mode <= 1'b0;
    end else begin
      o_flash_program_select_pin_mode <= program_select_pin; // RQ16
    end
  end

  assign o_sfr_rdata           = rdata_q;
  assign o_cpu_standby         = standby_q;
  assign o_usb_suspend         = suspend_q;
  assign o_pll_on              = pll_q;
  assign o_radio_mode          = radio_q;
  assign o_low_frequency_clock = lf_clk_q;
  assign o_common_wakeup_event = wu_q;

endmodule

/* verification/pmwc_chk.sv */
module pmwc_chk
  import pmwc_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_wr,
  input wire logic       o_cpu_standby,
  input wire logic       o_usb_suspend,
  input wire logic       o_pll_on,
  input wire logic       o_flash_program_select_pin_mode,
  input wire logic       o_low_frequency_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // The software PLL enable is shadowed here so the suspended case can be judged.
  logic        pll_sw_q;
  logic        lf_prev_q;
  logic [11:0] lf_cnt_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pll_sw_q <= 1'b1;
    end else if (i_sfr_wr && i_sfr_addr == A_CLK_CTRL) begin
      pll_sw_q <= i_sfr_wdata[PLL_EN_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      lf_prev_q <= 1'b0;
      lf_cnt_q  <= 12'h000;
    end else begin
      lf_prev_q <= o_low_frequency_clock;
      lf_cnt_q  <= (o_low_frequency_clock != lf_prev_q) ? 12'h000 : lf_cnt_q + 12'h001;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_state: assert property (
    $fell(i_reset) |-> o_pll_on && !o_cpu_standby && !o_usb_suspend)
    else $error("wrong power state after reset");
  a_sleep_standby: assert property (
    i_sfr_wr && i_sfr_addr == A_PWR_DOWN && i_sfr_wdata[2:0] != 3'h0 && !o_flash_program_select_pin_mode
    |=> o_cpu_standby || o_flash_program_select_pin_mode)
    else $error("processor did not enter standby");
  a_usb_suspend: assert property (
    i_sfr_wr && i_sfr_addr == A_USB_SLEEP && i_sfr_wdata == SLEEP_CMD && !o_flash_program_select_pin_mode
    |=> o_usb_suspend || o_flash_program_select_pin_mode)
    else $error("usb did not suspend");
  a_pll_usb_on: assert property (
    !o_usb_suspend |=> o_pll_on)
    else $error("pll off while usb active");
  a_pll_deep_off: assert property (
    o_usb_suspend && o_cpu_standby && !o_flash_program_select_pin_mode |=> !o_pll_on || o_flash_program_select_pin_mode)
    else $error("pll on in deep sleep");
  a_pll_soft_ctrl: assert property (
    o_usb_suspend && !o_cpu_standby && !o_flash_program_select_pin_mode |=> o_flash_program_select_pin_mode || o_pll_on == $past(pll_sw_q))
    else $error("pll ignores software enable");
  a_lf_running: assert property (
    lf_cnt_q < 12'h640)
    else $error("slow clock stopped");
  a_program_select_pin_forces: assert property (
    o_flash_program_select_pin_mode |=> !o_cpu_standby && !o_usb_suspend && o_pll_on)
    else $error("power states active in programming mode");

  c_standby: cover property ($rose(o_cpu_standby));
  c_pll_off: cover property ($fell(o_pll_on));
  c_program_select_pin: cover property ($rose(o_flash_program_select_pin_mode));
endmodule

/* verification/pmwc_cpu_model.sv */
module pmwc_cpu_model
  import pmwc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_sfr_rdata,
  output logic [7:0]      o_sfr_addr,
  output logic [7:0]      o_sfr_wdata,
  output logic            o_sfr_wr,
  output logic            o_sfr_rd,
  output logic            o_timeout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sfr_addr  = 8'h00;
    o_sfr_wdata = 8'h00;
    o_sfr_wr    = 1'b0;
    o_sfr_rd    = 1'b0;
    o_timeout   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_sfr_addr  = a;
    o_sfr_wdata = d;
    o_sfr_wr    = 1'b1;
    @(negedge i_sys_clk);
    o_sfr_wr    = 1'b0;
  endtask

  // Read data is taken one full cycle after the strobe, where it stands settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_sfr_addr = a;
    o_sfr_rd   = 1'b1;
    @(negedge i_sys_clk);
    o_sfr_rd   = 1'b0;
    @(negedge i_sys_clk);
    d = i_sfr_rdata;
  endtask

  task automatic ind(input logic [7:0] c);
    logic [7:0] s;
    wr(A_IND_CTRL, c);
    s = 8'h10;
    for (int n = 0; n < 2000 && s[IC_BUSY] !== 1'b0; n++) rd(A_IND_CTRL, s);
    if (s[IC_BUSY] !== 1'b0) o_timeout = 1'b1;
  endtask
endmodule

/* verification/pmwc_ctrl_tb.sv */
module pmwc_ctrl_tb;
  import pmwc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rst, rf, usbi, rtc, res, program_select_pin;
  logic [7:0] ien;
  logic [5:0] pins;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, to, standby, susp, pll, program_select_pin_mode, lf, ev;
  logic [1:0] radio;
  logic [3:0] code;
  int         fails, cmp_count;

  pmwc_ctrl uut (.i_sys_clk(clk), .i_reset(rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_interrupt_enable_group_one(ien), .i_rf_irq(rf), .i_usb_irq(usbi),
    .i_rtc_wakeup(rtc), .i_usb_resume(res), .i_port0_pin(pins), .i_program_select_pin(program_select_pin),
    .o_sfr_rdata(rdata), .o_cpu_standby(standby), .o_usb_suspend(susp), .o_pll_on(pll),
    .o_cpu_clk_code(code), .o_radio_mode(radio), .o_flash_program_select_pin_mode(program_select_pin_mode),
    .o_low_frequency_clock(lf), .o_common_wakeup_event(ev));

  pmwc_cpu_model cpu (.i_sys_clk(clk), .i_sfr_rdata(rdata), .o_sfr_addr(addr), .o_sfr_wdata(wdata),
    .o_sfr_wr(wr), .o_sfr_rd(rd), .o_timeout(to));

  always #5 clk = ~clk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge to) begin
    fails++;
    give_verdict();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rdw(input logic [2:0] a, output logic [15:0] w);
    logic [7:0] hi, lo;
    cpu.ind({5'h00, a});
    cpu.rd(A_IND_HIGH, hi);
    cpu.rd(A_IND_LOW, lo);
    w = {hi, lo};
  endtask

  task automatic wrw(input logic [2:0] a, input logic [15:0] w);
    cpu.wr(A_IND_HIGH, w[15:8]);
    cpu.wr(A_IND_LOW, w[7:0]);
    cpu.ind({5'h01, a});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] b;
    chk({7'h0, standby}, 8'h00);
    chk({7'h0, susp}, 8'h00);
    chk({7'h0, pll}, 8'h01);
    chk({6'h0, radio}, 8'h00);
    chk({4'h0, code}, 8'h08);
    cpu.rd(A_CLK_CTRL, b);
    chk(b, CLK_CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      cpu.wr(A_RADIO_CTRL, 8'(i));
      idle(1);
      chk({6'h0, radio}, 8'(i));
    end
  endtask

  task automatic t_wake;
    cpu.wr(A_WAKE_CONF, 8'hc0);
    cpu.wr(A_PWR_DOWN, 8'h04);
    idle(2);
    chk({7'h0, standby}, 8'h01);
    rf = 1'b1;
    idle(4);
    chk({7'h0, standby}, 8'h01);
    rf = 1'b0;
    cpu.wr(A_WAKE_CONF, 8'h80);
    rf = 1'b1;
    idle(3);
    chk({7'h0, standby}, 8'h00);
    rf = 1'b0;
    cpu.wr(A_PWR_DOWN, SLEEP_CMD);
    usbi = 1'b1;
    idle(4);
    chk({7'h0, standby}, 8'h01);
    ien = 8'h10;
    idle(3);
    chk({7'h0, standby}, 8'h00);
    usbi = 1'b0;
    ien = 8'h00;
  endtask

  task automatic t_pll;
    cpu.wr(A_USB_SLEEP, SLEEP_CMD);
    cpu.wr(A_CLK_CTRL, 8'h00);
    idle(2);
    chk({7'h0, susp}, 8'h01);
    chk({7'h0, pll}, 8'h00);
    chk({4'h0, code}, 8'h00);
    cpu.wr(A_CLK_CTRL, 8'h80);
    cpu.wr(A_PWR_DOWN, SLEEP_CMD);
    idle(3);
    chk({7'h0, pll}, 8'h00);
    rf = 1'b1;
    idle(3);
    rf = 1'b0;
    chk({7'h0, pll}, 8'h01);
    res = 1'b1;
    idle(6);
    res = 1'b0;
    chk({7'h0, susp}, 8'h00);
    idle(3);
    cpu.wr(A_USB_SLEEP, SLEEP_CMD);
    idle(1);
    chk({7'h0, susp}, 8'h01);
    cpu.wr(A_USB_SLEEP, 8'h00);
    idle(2);
    chk({7'h0, susp}, 8'h00);
  endtask

  task automatic wait_ev;
    int n;
    n = 0;
    while (ev !== 1'b1 && n < 25000) begin
      @(negedge clk);
      n++;
    end
    if (n == 25000) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic wait_lf(input logic v, inout int n);
    int k;
    k = 0;
    while (lf !== v && k < 4000) begin
      @(negedge clk);
      k++;
      n++;
    end
    if (k == 4000) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic t_lf;
    int n;
    n = 0;
    wait_lf(1'b0, n);
    wait_lf(1'b1, n);
    n = 0;
    wait_lf(1'b0, n);
    wait_lf(1'b1, n);
    chk(8'(n >> 8), 8'(LF_CYC >> 8));
    chk(8'(n), 8'(LF_CYC));
  endtask

  task automatic t_pins;
    logic [15:0] w;
    wrw(IA_WAKE_A, 16'h0005);
    wrw(IA_WAKE_B, 16'hff8c);
    pins[0] = 1'b1;
    wait_ev();
    rdw(IA_WAKE_A, w);
    chk(w[15:8], 8'h00);
    chk(w[7:0], 8'h01);
    rdw(IA_WAKE_A, w);
    chk(w[7:0], 8'h00);
    rdw(IA_WAKE_B, w);
    chk(w[7:0], 8'h01);
    pins = 6'h30;
    wait_ev();
    rdw(IA_WAKE_B, w);
    chk(w[7:0], 8'h10);
    idle(10000);
    pins[5:4] = 2'h0;
    wait_ev();
    idle(2);
    rtc = 1'b1;
    idle(1);
    rtc = 1'b0;
    idle(4);
    rdw(IA_WAKE_B, w);
    chk(w[15:8], 8'h01);
    chk(w[7:0], 8'h30);
    rdw(IA_WAKE_A, w);
    chk(w[15:8], 8'h01);
    chk(w[7:0], 8'h30);
  endtask

  task automatic t_program_select_pin;
    cpu.wr(A_PWR_DOWN, SLEEP_CMD);
    idle(2);
    program_select_pin = 1'b1;
    idle(6);
    chk({7'h0, program_select_pin_mode}, 8'h01);
    chk({7'h0, standby}, 8'h00);
    program_select_pin = 1'b0;
    idle(4);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {rf, usbi, rtc, res, program_select_pin} = 5'h00;
    ien = 8'h00;
    pins = 6'h00;
    fails = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_lf();
    t_wake();
    t_pll();
    t_pins();
    t_program_select_pin();
    give_verdict();
  end
endmodule

bind pmwc_ctrl pmwc_chk u_chk (.i_sys_clk, .i_reset, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .o_cpu_standby,
  .o_usb_suspend, .o_pll_on, .o_flash_program_select_pin_mode, .o_low_frequency_clock);
